// ---- rtl/usr_defines.vh ----
/*
 constants for the universal shift register with synchronous clear:
 register offsets, field positions, reset values, mode codes and bus answers.
 assumes it is included by bare name from the design file.
*/
`ifndef USR_DEFINES_VH
`define USR_DEFINES_VH

////////////////////////////////////////////////////////////////////////////////
// register byte offsets on the bus
`define USR_OFS_CTRL 4'h0
`define USR_OFS_LOAD 4'h4
`define USR_OFS_STAT 4'h8
`define USR_ADDR_W 4

////////////////////////////////////////////////////////////////////////////////
// control register fields
`define USR_CTRL_SWSEL 0
`define USR_CTRL_MODE_LO 1
`define USR_CTRL_MODE_HI 2
`define USR_CTRL_DRIGHT 3
`define USR_CTRL_DLEFT 4
`define USR_CTRL_W 5
`define USR_CTRL_RST 5'h00

////////////////////////////////////////////////////////////////////////////////
// status register fields
`define USR_STAT_MODE_LO 8
`define USR_STAT_MODE_HI 9
`define USR_STAT_DRIVE 10

////////////////////////////////////////////////////////////////////////////////
// mode codes {high select, low select}
`define USR_MODE_HOLD 2'h0
`define USR_MODE_SHR 2'h1
`define USR_MODE_SHL 2'h2
`define USR_MODE_LOAD 2'h3

////////////////////////////////////////////////////////////////////////////////
// reset values and bus answers
`define USR_STATE_RST 8'h00
`define USR_LOAD_RST 8'h00
`define USR_RESP_OKAY 2'h0
`define USR_RESP_SLVERR 2'h2

`endif

// ---- rtl/usr_shift_reg.v ----
/*
 eight-bit universal shift/storage register with synchronous clear,
 shared tri-state parallel pins, serial cascade outputs and an
 axi4-lite register slave for observation and software stepping.
 assumes one clock aclk, all pin inputs synchronous to it, and a
 pad ring that resolves the parallel pins from the enables.
*/
`timescale 1ns/10ps
`default_nettype none
`include "usr_defines.vh"

////////////////////////////////////////////////////////////////////////////////
module usr_shift_reg #(
	parameter WIDTH = 8
) (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// mode and clear pins
	input wire mode_select_low,
	input wire mode_select_high,
	input wire sync_clear_n,
	// serial cascade pins
	input wire right_shift_serial_in,
	input wire left_shift_serial_in,
	output wire serial_out_bit_zero,
	output wire serial_out_bit_seven,
	// parallel pin three-signal view
	input wire out_enable_first_n,
	input wire out_enable_second_n,
	input wire [WIDTH-1:0] parallel_bus_pins_i,
	output wire [WIDTH-1:0] parallel_bus_pins_o,
	output wire [WIDTH-1:0] parallel_bus_pins_oe,
	// axi4-lite write address
	input wire [`USR_ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	// axi4-lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	// axi4-lite write response
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read address
	input wire [`USR_ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	// axi4-lite read data
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready
);

	////////////////////////////////////////////////////////////////////////////
	// next-state function of the storage stage
	function [WIDTH-1:0] usr_next;
		input [WIDTH-1:0] cur;
		input [1:0] mode;
		input clr_n;
		input d_right;
		input d_left;
		input [WIDTH-1:0] pins;
		begin
			// clear outranks every mode
			if (!clr_n) begin
				usr_next = `USR_STATE_RST;
			end else begin
				// mode code is {high select, low select}
				case (mode)
					`USR_MODE_LOAD: usr_next = pins;
					`USR_MODE_SHR: usr_next = {cur[WIDTH-2:0], d_right};
					`USR_MODE_SHL: usr_next = {d_left, cur[WIDTH-1:1]};
					default: usr_next = cur;
				endcase
			end
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// register map decode, shared by the write and read paths
	function usr_mapped;
		input [`USR_ADDR_W-1:0] addr;
		begin
			// only the three word offsets answer okay
			case (addr)
				`USR_OFS_CTRL: usr_mapped = 1'b1;
				`USR_OFS_LOAD: usr_mapped = 1'b1;
				`USR_OFS_STAT: usr_mapped = 1'b1;
				default: usr_mapped = 1'b0;
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// storage and pin driver state
	reg [WIDTH-1:0] state_r; // the eight stored bits
	reg [WIDTH-1:0] state_nxt;
	reg [WIDTH-1:0] pin_oe_r; // registered buffer enables
	reg [WIDTH-1:0] pin_oe_nxt;
	reg ser0_r; // cascade copy of bit 0
	reg ser7_r; // cascade copy of bit 7

	// software control and load registers
	reg [`USR_CTRL_W-1:0] ctrl_r;
	reg [WIDTH-1:0] load_r; // load source in software mode

	// effective controls after the software selector
	reg [1:0] mode_eff;
	reg d_right_eff;
	reg d_left_eff;
	reg [WIDTH-1:0] load_src;

	// write channel holding state
	reg awready_r;
	reg wready_r;
	reg bvalid_r;
	reg [1:0] bresp_r;
	reg aw_hold_r; // address taken, waiting for data
	reg w_hold_r; // data taken, waiting for address
	reg [`USR_ADDR_W-1:0] aw_addr_r;
	reg [31:0] w_data_r;
	reg [3:0] w_strb_r;

	// read channel state
	reg arready_r;
	reg rvalid_r;
	reg [1:0] rresp_r;
	reg [31:0] rdata_r;

	// decode helpers
	wire do_write; // both halves present, no answer pending
	wire wr_ctrl;
	wire wr_load;
	wire wr_hit;
	reg [31:0] rd_word;
	reg rd_hit;

	////////////////////////////////////////////////////////////////////////////
	// pick pin controls or software controls
	// the clear pin is never taken over by software
	always @* begin
		if (ctrl_r[`USR_CTRL_SWSEL]) begin
			// software drives mode, serial bits and load data
			mode_eff = {ctrl_r[`USR_CTRL_MODE_HI], ctrl_r[`USR_CTRL_MODE_LO]};
			d_right_eff = ctrl_r[`USR_CTRL_DRIGHT];
			d_left_eff = ctrl_r[`USR_CTRL_DLEFT];
			load_src = load_r;
		end else begin
			// pins drive everything
			mode_eff = {mode_select_high, mode_select_low};
			d_right_eff = right_shift_serial_in;
			d_left_eff = left_shift_serial_in;
			load_src = parallel_bus_pins_i;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// next state and next buffer enables
	always @* begin
		// inputs are assumed settled at the edge by the far side
		state_nxt = usr_next(state_r, mode_eff, sync_clear_n,
			d_right_eff, d_left_eff, load_src);
		// either enable high or load mode floats the pins
		if (out_enable_first_n || out_enable_second_n) begin
			pin_oe_nxt = {WIDTH{1'b0}};
		end else if (mode_eff == `USR_MODE_LOAD) begin
			pin_oe_nxt = {WIDTH{1'b0}};
		end else begin
			pin_oe_nxt = {WIDTH{1'b1}};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// storage flip-flops, rising edge only
	always @(posedge aclk) begin
		if (!aresetn) begin
			// reset empties the register and floats the pins
			state_r <= `USR_STATE_RST;
			pin_oe_r <= {WIDTH{1'b0}};
			ser0_r <= 1'b0;
			ser7_r <= 1'b0;
		end else begin
			// enables do not gate the update
			state_r <= state_nxt;
			pin_oe_r <= pin_oe_nxt;
			// cascade copies never float
			ser0_r <= state_nxt[0];
			ser7_r <= state_nxt[WIDTH-1];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// write decode
	assign do_write = aw_hold_r && w_hold_r && !bvalid_r;
	assign wr_ctrl = (aw_addr_r == `USR_OFS_CTRL);
	assign wr_load = (aw_addr_r == `USR_OFS_LOAD);
	// a status write is answered okay but changes nothing
	assign wr_hit = usr_mapped(aw_addr_r);

	////////////////////////////////////////////////////////////////////////////
	// write channels: address and data taken in either order
	always @(posedge aclk) begin
		if (!aresetn) begin
			// both write channels open after reset
			awready_r <= 1'b1;
			wready_r <= 1'b1;
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			aw_addr_r <= {`USR_ADDR_W{1'b0}};
			w_data_r <= 32'h00000000;
			w_strb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= `USR_RESP_OKAY;
		end else begin
			// catch the address
			if (s_axi_awvalid && awready_r) begin
				aw_hold_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
				awready_r <= 1'b0;
			end
			// catch the data
			if (s_axi_wvalid && wready_r) begin
				w_hold_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
				wready_r <= 1'b0;
			end
			// both present: answer, status stays read-only
			if (do_write) begin
				aw_hold_r <= 1'b0;
				w_hold_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= wr_hit ? `USR_RESP_OKAY : `USR_RESP_SLVERR;
			end
			// answer taken, reopen both channels
			if (bvalid_r && s_axi_bready) begin
				bvalid_r <= 1'b0;
				awready_r <= 1'b1;
				wready_r <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// software registers, low byte lane only
	always @(posedge aclk) begin
		if (!aresetn) begin
			// software select off, pins in control
			ctrl_r <= `USR_CTRL_RST;
			load_r <= `USR_LOAD_RST;
		end else if (do_write && w_strb_r[0]) begin
			// upper byte lanes are ignored, lane zero holds every field
			// control steers mode source
			if (wr_ctrl) begin
				ctrl_r <= w_data_r[`USR_CTRL_W-1:0];
			end
			// load word for software parallel load
			if (wr_load) begin
				load_r <= w_data_r[WIDTH-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read decode
	always @* begin
		rd_word = 32'h00000000;
		// unmapped offsets read as zero with an error answer
		rd_hit = usr_mapped(s_axi_araddr);
		case (s_axi_araddr)
			`USR_OFS_CTRL: rd_word[`USR_CTRL_W-1:0] = ctrl_r;
			`USR_OFS_LOAD: rd_word[WIDTH-1:0] = load_r;
			`USR_OFS_STAT: begin
				// stored bits, mode in force, driver state
				rd_word[WIDTH-1:0] = state_r;
				rd_word[`USR_STAT_MODE_LO] = mode_eff[0];
				rd_word[`USR_STAT_MODE_HI] = mode_eff[1];
				rd_word[`USR_STAT_DRIVE] = pin_oe_r[0];
			end
			default: rd_word = 32'h00000000;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// read channel: one word per request
	always @(posedge aclk) begin
		if (!aresetn) begin
			// ready for an address, no answer pending
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
			rresp_r <= `USR_RESP_OKAY;
			rdata_r <= 32'h00000000;
		end else if (s_axi_arvalid && arready_r) begin
			// capture the word at address time
			// the word stays frozen until the answer is taken
			arready_r <= 1'b0;
			rvalid_r <= 1'b1;
			rdata_r <= rd_word;
			rresp_r <= rd_hit ? `USR_RESP_OKAY : `USR_RESP_SLVERR;
		end else if (rvalid_r && s_axi_rready) begin
			// answer taken, accept the next address
			rvalid_r <= 1'b0;
			arready_r <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs straight from flip-flops
	// cascade taps, driven whatever the enables say
	assign serial_out_bit_zero = ser0_r;
	assign serial_out_bit_seven = ser7_r;
	assign parallel_bus_pins_o = state_r;
	assign parallel_bus_pins_oe = pin_oe_r;
	// bus handshakes and answers
	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = rdata_r;

endmodule
`default_nettype wire

// ---- verification/usr_shift_reg_sva.sv ----
/* checker on the shift register pins and write answers.
 assumes one clock aclk and a synchronous active-low aresetn. */
`timescale 1ns/10ps
`default_nettype none
module usr_sva (
	// clock, reset, mode and clear
	input wire logic aclk, aresetn, mode_select_low, mode_select_high, sync_clear_n,
	// serial pins
	input wire logic right_shift_serial_in, left_shift_serial_in,
	input wire logic serial_out_bit_zero, serial_out_bit_seven,
	// parallel pins
	input wire logic out_enable_first_n, out_enable_second_n,
	input wire logic [7:0] parallel_bus_pins_i, parallel_bus_pins_o, parallel_bus_pins_oe,
	// write answer
	input wire logic s_axi_bvalid, s_axi_bready,
	input wire logic [1:0] s_axi_bresp
);
	wire [1:0] md = {mode_select_high, mode_select_low}; // selected operation
	wire run = sync_clear_n; // clear idle
	wire off = out_enable_first_n | out_enable_second_n | (md == 2'h3); // drivers to float
	logic live_r = 1'b0; // high once an edge has been clocked out of reset
	// a property started at the releasing edge would still see reset outputs
	always @(posedge aclk) live_r <= aresetn;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn || !live_r);
	////////////////////////////////////////////////////////////////////////////////
	a_clear_zero: assert property (!run |=> parallel_bus_pins_o == 8'h00)
		else $error("clear left bits set");
	a_hold_state: assert property (run && md == 2'h0 |=> $stable(parallel_bus_pins_o))
		else $error("hold changed state");
	a_load_pins: assert property (run && md == 2'h3 |=>
		parallel_bus_pins_o == $past(parallel_bus_pins_i))
		else $error("load took wrong data");
	a_shift_right: assert property (run && md == 2'h1 |=>
		parallel_bus_pins_o == {$past(parallel_bus_pins_o[6:0]), $past(right_shift_serial_in)})
		else $error("right shift wrong");
	a_shift_left: assert property (run && md == 2'h2 |=>
		parallel_bus_pins_o == {$past(left_shift_serial_in), $past(parallel_bus_pins_o[7:1])})
		else $error("left shift wrong");
	a_serial_taps: assert property (
		serial_out_bit_zero == parallel_bus_pins_o[0] &&
		serial_out_bit_seven == parallel_bus_pins_o[7])
		else $error("serial outputs differ from state");
	a_pins_float: assert property (off |=> parallel_bus_pins_oe == 8'h00)
		else $error("pins driven while disabled");
	a_pins_drive: assert property (!off |=> parallel_bus_pins_oe == 8'hFF)
		else $error("pins not driven");
	a_bresp_stand: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	c_load: cover property (run && md == 2'h3);
	c_clear: cover property (!run && md == 2'h1);
	c_shift_float: cover property (run && out_enable_first_n && md == 2'h2);
	c_answer_wait: cover property (s_axi_bvalid && !s_axi_bready);
endmodule
bind usr_shift_reg usr_sva chk (.*);
`default_nettype wire

// ---- verification/usr_bus_partner.sv ----
/* far side of the parallel pins: a bus agent and the resolved wire.
 assumes the agent request changes only just after a rising aclk. */
`timescale 1ns/10ps
`default_nettype none
module usr_bus_partner (
	// clock
	input wire logic aclk,
	// agent request
	input wire logic drv_en,
	input wire logic [7:0] drv_data,
	// device pin view and resolved level
	input wire logic [7:0] parallel_bus_pins_o, parallel_bus_pins_oe,
	output logic [7:0] parallel_bus_pins_i
);
	logic [7:0] last_r = 8'h00; // last wire level, seeds the float pattern
	// device wins, then agent, else an undriven wire that toggles
	assign parallel_bus_pins_i = (parallel_bus_pins_oe & parallel_bus_pins_o) |
		(~parallel_bus_pins_oe & (drv_en ? drv_data : ~last_r));
	// remember the level at each edge
	always @(posedge aclk) begin
		last_r <= parallel_bus_pins_i;
	end
endmodule
`default_nettype wire

// ---- verification/universal_shift_register_sync_clear_tb_top.sv ----
/* random pin traffic against a bench model, then register access.
 assumes the bus agent and the checker are compiled before it. */
`timescale 1ns/10ps
`default_nettype none
module universal_shift_register_sync_clear_tb_top;
	logic aclk, aresetn, mode_select_low, mode_select_high, sync_clear_n, drv_en;
	logic right_shift_serial_in, left_shift_serial_in, out_enable_first_n, out_enable_second_n;
	logic serial_out_bit_zero, serial_out_bit_seven;
	logic [7:0] parallel_bus_pins_i, parallel_bus_pins_o, parallel_bus_pins_oe, drv_data;
	logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int miscompares = 0;
	int check_count = 0;
	logic [31:0] seed = 32'h87DD9E75; // fixed seed
	logic [7:0] exp_st, exp_oe, exp_last, pin; // bench model of state, drivers, wire
	usr_shift_reg dut (.*);
	usr_bus_partner peer (.*);
	////////////////////////////////////////////////////////////////////////////////
	// xorshift step
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	// next state from clear, mode, serial bits and wire level
	function automatic logic [7:0] nxt(input logic [7:0] q, p, input logic [1:0] m,
		input logic c, r, l);
		if (!c) return 8'h00;
		case (m)
			2'h1: return {q[6:0], r};
			2'h2: return {l, q[7:1]};
			2'h3: return p;
			default: return q;
		endcase
	endfunction
	task automatic cmp(input string n, input logic [31:0] e, g);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic final_report;
		if (miscompares == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// write: offer both channels, release each when taken, then the answer
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b0;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
		// let the answer wait one cycle, then take it at the handshake edge
		do @(posedge aclk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b1;
		@(posedge aclk);
		cmp("bresp", er, s_axi_bresp);
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		cmp("rdata", ed, s_axi_rdata);
		cmp("rresp", er, s_axi_rresp);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	// watchdog
	initial begin
		#20000;
		miscompares++;
		final_report;
	end
	initial begin
		{aresetn, mode_select_low, mode_select_high, right_shift_serial_in, left_shift_serial_in} = 5'h00;
		{out_enable_first_n, out_enable_second_n, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = 44'h0;
		{sync_clear_n, drv_en, s_axi_bready, s_axi_rready} = 4'hF;
		drv_data = 8'h3C;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rd(4'h0, 32'h0, 2'h0);
		rd(4'h4, 32'h0, 2'h0);
		rd(4'h8, 32'h400, 2'h0);
		{exp_st, exp_oe, exp_last} = {8'h00, 8'hFF, 8'h3C};
		for (int i = 0; i < 400; i++) begin
			@(posedge aclk);
			cmp("state", exp_st, parallel_bus_pins_o);
			cmp("serial", {exp_st[7], exp_st[0]},
				{serial_out_bit_seven, serial_out_bit_zero});
			cmp("drive", exp_oe, parallel_bus_pins_oe);
			pin = (exp_oe & exp_st) | (~exp_oe & (drv_en ? drv_data : ~exp_last));
			exp_last = pin;
			exp_st = nxt(exp_st, pin, {mode_select_high, mode_select_low}, sync_clear_n,
				right_shift_serial_in, left_shift_serial_in);
			exp_oe = (out_enable_first_n | out_enable_second_n |
				(mode_select_high & mode_select_low)) ? 8'h00 : 8'hFF;
			seed = xs(seed);
			// settle in hold with drivers on before register access
			pin = (i > 396) ? 8'h70 : seed[7:0];
			{mode_select_high, mode_select_low, right_shift_serial_in, left_shift_serial_in} <= pin[3:0];
			sync_clear_n <= |pin[6:4];
			out_enable_first_n <= pin[7] & seed[8];
			out_enable_second_n <= (i < 397) & seed[9] & seed[10];
			drv_en <= seed[11];
			drv_data <= seed[19:12];
		end
		rd(4'h8, {21'h0, exp_oe[0], 2'h0, exp_st}, 2'h0);
		wr(4'h4, 32'hFFFFFF5A, 4'hF, 2'h0);
		rd(4'h4, 32'h5A, 2'h0);
		wr(4'h4, 32'h11, 4'hE, 2'h0);
		rd(4'h4, 32'h5A, 2'h0);
		wr(4'h0, 32'hFFFFFFFE, 4'hF, 2'h0);
		rd(4'h0, 32'h1E, 2'h0);
		wr(4'h8, 32'hFF, 4'hF, 2'h0);
		wr(4'hC, 32'h1, 4'hF, 2'h2);
		rd(4'hC, 32'h0, 2'h2);
		rd(4'h8, {21'h0, exp_oe[0], 2'h0, exp_st}, 2'h0);
		// software select while the clear pin holds the register empty
		sync_clear_n <= 1'b0;
		wr(4'h0, 32'h15, 4'h1, 2'h0);
		rd(4'h0, 32'h15, 2'h0);
		rd(4'h8, 32'h600, 2'h0);
		wr(4'h0, 32'h0, 4'h1, 2'h0);
		final_report;
	end
endmodule
`default_nettype wire
